// ===== rtl/dfc_chain.sv
/*
  dfc_chain: distance filter chain with register port and output delay.
  assumes meas_valid is a one-cycle pulse on clk per measurement interval,
  poll_pin is asynchronous, and the register master never strobes
  read and write together.
*/
`timescale 1ns/1ns
module dfc_chain #(
  parameter int DLY_TICK = dfc_pkg::DLY_STEP_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire dfc_pkg::dfc_bus_t bus,
  output logic [31:0] rdata,
  input wire logic meas_valid,
  input wire dfc_pkg::dfc_dist_t meas_dist,
  input wire logic poll_pin,
  output logic result_valid,
  output dfc_pkg::dfc_dist_t result_dist,
  output logic out_valid,
  output dfc_pkg::dfc_dist_t out_dist
);
  import dfc_pkg::*;

  // step a distance toward a target by at most lim
  function automatic dfc_dist_t toward(input dfc_dist_t c, input dfc_dist_t t,
                                       input dfc_dist_t lim);
    if (absd(c, t) <= lim) return t;
    return (t > c) ? dfc_dist_t'(c + lim) : dfc_dist_t'(c - lim);
  endfunction

  dfc_ctrl_t ctrl_q; // stored selections
  logic [9:0] setm_q; // set size M
  logic [2:0] x_q, y_q; // stability counts
  logic [7:0] n_q; // average length N
  dfc_dist_t rate_q; // max change per interval
  dfc_dist_t dly_q; // output delay in 5 ms steps
  logic sf_wait_q; // slow-fast armed, waiting for exit
  logic code_wr; // code register write
  dfc_rej_t rej_e; // effective selections
  dfc_avg_t avg_e;
  dfc_lim_t lim_e;

  ////////////////////////////////////////////////////////////////////
  // register writes
  assign code_wr = bus.wr && bus.addr == A_CODE;

  // control word; codes edit it as well
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= dfc_ctrl_t'(CTRL_RST);
    end else if (bus.wr && bus.addr == A_CTRL) begin
      ctrl_q <= dfc_ctrl_t'(bus.wdata[7:0]);
    end else if (code_wr && bus.wdata[7:0] == CODE_SMOOTH) begin
      ctrl_q.lim <= (ctrl_q.lim == LIM_SF) ? LIM_OFF : LIM_SF;
    end else if (code_wr && bus.wdata[7:0] == CODE_RESTORE) begin
      ctrl_q <= dfc_ctrl_t'(CTRL_RST);
    end
  end

  // arming flag: toggle-on sets, leaving configuration clears
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sf_wait_q <= 1'b0;
    end else if (code_wr && bus.wdata[7:0] == CODE_SMOOTH && ctrl_q.lim != LIM_SF) begin
      sf_wait_q <= 1'b1;
    end else if (!ctrl_q.unlocked || (code_wr && bus.wdata[7:0] == CODE_RESTORE)) begin
      sf_wait_q <= 1'b0;
    end
  end

  // parameter registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      setm_q <= SETM_RST;
      x_q <= STABX_RST;
      y_q <= STABY_RST;
      n_q <= AVGN_RST;
      rate_q <= RATE_RST;
      dly_q <= DLY_RST;
    end else if (bus.wr) begin
      case (bus.addr)
        A_SETM: setm_q <= bus.wdata[9:0];
        A_STAB: begin
          x_q <= bus.wdata[STAB_X_LSB +: 3];
          y_q <= bus.wdata[STAB_Y_LSB +: 3];
        end
        A_AVGN: n_q <= bus.wdata[7:0];
        A_RATE: rate_q <= bus.wdata[15:0];
        A_DLY: dly_q <= bus.wdata[15:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // effective selections: one option per stage by construction
  always_comb begin
    rej_e = ctrl_q.rej;
    avg_e = ctrl_q.avg;
    lim_e = ctrl_q.lim;
    if (ctrl_q.poll && rej_e == REJ_STAB) rej_e = REJ_OFF;
    if (ctrl_q.poll && avg_e == AVG_RUN) avg_e = AVG_OFF;
    if (avg_e == AVG_RSV) avg_e = AVG_OFF;
    if (lim_e == LIM_RSV) lim_e = LIM_OFF;
    if ((ctrl_q.poll || sf_wait_q) && lim_e == LIM_SF) lim_e = LIM_OFF;
    if (ctrl_q.unlocked) begin
      rej_e = REJ_OFF;
      avg_e = AVG_OFF;
      lim_e = LIM_OFF;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // poll synchroniser and pass control
  logic p1_q, p2_q, p3_q; // p1 feeds p2 only
  logic run_q, pend_q; // pass active, one pass queued
  logic m_ok, init_q, mfirst, mstep, done;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      p1_q <= 1'b0;
      p2_q <= 1'b0;
      p3_q <= 1'b0;
    end else begin
      p1_q <= poll_pin;
      p2_q <= p1_q;
      p3_q <= p2_q;
    end
  end

  // a poll during a pass is queued, one deep; further polls merge into it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (!ctrl_q.poll) begin
      run_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (p2_q && !p3_q) begin
      if (run_q && !done) pend_q <= 1'b1;
      else run_q <= 1'b1;
    end else if (done) begin
      run_q <= pend_q;
      pend_q <= 1'b0;
    end
  end

  assign m_ok = meas_valid && (!ctrl_q.poll || run_q);
  assign mfirst = m_ok && !init_q;
  assign mstep = m_ok && init_q;

  // cleared only by reset, the power-on condition
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) init_q <= 1'b0;
    else if (mfirst) init_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////
  // stage 1: input rejection
  logic [9:0] mm, rcnt_q;
  dfc_dist_t ext_q, s1_d;
  logic s1_v, stab_ok;

  dfc_stab dfc_stab_inst (
    .clk(clk),
    .resetn(resetn),
    .load(mfirst),
    .step(mstep),
    .d(meas_dist),
    .x(x_q),
    .y(y_q),
    .ok(stab_ok)
  );

  always_comb begin
    mm = (setm_q < 10'h002) ? 10'h002 : setm_q;
    s1_v = mstep;
    s1_d = meas_dist;
    case (rej_e)
      REJ_NEAR, REJ_FAR: begin
        // first of a set starts fresh, later ones compete
        if (rcnt_q != 10'h000) begin
          s1_d = (rej_e == REJ_FAR) ? ((ext_q > meas_dist) ? ext_q : meas_dist)
                                    : ((ext_q < meas_dist) ? ext_q : meas_dist);
        end
        s1_v = mstep && rcnt_q == mm - 10'h001;
      end
      REJ_STAB: s1_v = mstep && stab_ok;
      default: s1_v = mstep;
    endcase
  end

  // set counter and running extreme
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rcnt_q <= 10'h000;
      ext_q <= '0;
    end else if (rej_e != REJ_NEAR && rej_e != REJ_FAR) begin
      rcnt_q <= 10'h000;
    end else if (mstep) begin
      rcnt_q <= (rcnt_q == mm - 10'h001) ? 10'h000 : rcnt_q + 10'h001;
      ext_q <= s1_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // stage 2: averaging
  logic [7:0] nn, bcnt_q, wp_q, fill_q;
  logic [23:0] bsum_q, rsum_q, bnext, rnext;
  dfc_dist_t seed_q, old, s2_d;
  dfc_dist_t ring [256]; // last N stage inputs
  logic s2_v;

  always_comb begin
    nn = (n_q < 8'h02) ? 8'h02 : n_q;
    bnext = bsum_q + {8'h00, s1_d};
    // until the ring is full the seed stands in for missing samples
    old = (fill_q < nn) ? seed_q : ring[wp_q];
    rnext = rsum_q + {8'h00, s1_d} - {8'h00, old};
    s2_v = s1_v;
    s2_d = s1_d;
    case (avg_e)
      AVG_BOX: begin
        s2_v = s1_v && bcnt_q == nn - 8'h01;
        s2_d = dfc_dist_t'(bnext / {16'h0000, nn});
      end
      AVG_RUN: s2_d = dfc_dist_t'(rnext / {16'h0000, nn});
      default: ;
    endcase
  end

  // boxcar block accumulator
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bcnt_q <= 8'h00;
      bsum_q <= 24'h000000;
    end else if (avg_e != AVG_BOX) begin
      bcnt_q <= 8'h00;
      bsum_q <= 24'h000000;
    end else if (s1_v) begin
      bcnt_q <= (bcnt_q == nn - 8'h01) ? 8'h00 : bcnt_q + 8'h01;
      bsum_q <= (bcnt_q == nn - 8'h01) ? 24'h000000 : bnext;
    end
  end

  // running sum; reseeded while not in use so a switch-on starts flat
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= 8'h00;
      fill_q <= 8'h00;
      rsum_q <= 24'h000000;
      seed_q <= '0;
    end else if (mfirst || (s1_v && avg_e != AVG_RUN)) begin
      wp_q <= 8'h00;
      fill_q <= 8'h00;
      seed_q <= mfirst ? meas_dist : s1_d;
      rsum_q <= {8'h00, (mfirst ? meas_dist : s1_d)} * {16'h0000, nn};
    end else if (s1_v) begin
      wp_q <= (wp_q == nn - 8'h01) ? 8'h00 : wp_q + 8'h01;
      fill_q <= (fill_q < nn) ? fill_q + 8'h01 : fill_q;
      rsum_q <= rnext;
    end
  end

  // ring storage, no reset needed behind the fill count
  always_ff @(posedge clk) begin
    if (s1_v && avg_e == AVG_RUN) ring[wp_q] <= s1_d;
  end

  ////////////////////////////////////////////////////////////////////
  // stage 3: distance limiting
  dfc_dist_t out_q, tgt_q, step_q, s3_d, step_d;
  logic res_v_q;

  always_comb begin
    s3_d = s2_d;
    step_d = 16'h0001;
    case (lim_e)
      LIM_RATE: s3_d = toward(out_q, s2_d, rate_q);
      LIM_SF: begin
        if (!near_tol(out_q, s2_d)) begin
          // a held new value doubles the slew each interval
          if (near_tol(s2_d, tgt_q)) step_d = step_q[15] ? step_q : step_q << 1;
          s3_d = toward(out_q, s2_d, step_q);
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_q <= '0;
      tgt_q <= '0;
      step_q <= 16'h0001;
    end else if (mfirst) begin
      out_q <= meas_dist;
      tgt_q <= meas_dist;
      step_q <= 16'h0001;
    end else if (s2_v) begin
      out_q <= s3_d;
      tgt_q <= s2_d;
      step_q <= step_d;
    end
  end

  assign done = mfirst || s2_v;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) res_v_q <= 1'b0;
    else res_v_q <= done;
  end

  assign result_valid = res_v_q;
  assign result_dist = out_q;

  ////////////////////////////////////////////////////////////////////
  // output delay, retriggered by every new result
  logic [19:0] tcnt_q;
  dfc_dist_t dcnt_q, held_q;
  logic dpend_q, tick;

  assign tick = tcnt_q == 20'(DLY_TICK - 1);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) tcnt_q <= 20'h00000;
    else if (res_v_q || tick) tcnt_q <= 20'h00000;
    else tcnt_q <= tcnt_q + 20'h00001;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dpend_q <= 1'b0;
      dcnt_q <= '0;
      held_q <= '0;
      out_valid <= 1'b0;
      out_dist <= '0;
    end else begin
      out_valid <= 1'b0;
      if (res_v_q && dly_q == 16'h0000) begin
        dpend_q <= 1'b0;
        out_valid <= 1'b1;
        out_dist <= out_q;
      end else if (res_v_q) begin
        dpend_q <= 1'b1;
        dcnt_q <= dly_q;
        held_q <= out_q;
      end else if (dpend_q && tick) begin
        dcnt_q <= dcnt_q - 16'h0001;
        if (dcnt_q == 16'h0001) begin
          dpend_q <= 1'b0;
          out_valid <= 1'b1;
          out_dist <= held_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register reads, data one cycle after the strobe
  logic [31:0] rd_d;

  always_comb begin
    case (bus.addr)
      A_CTRL: rd_d = {24'h000000, ctrl_q};
      A_SETM: rd_d = {22'h000000, setm_q};
      A_STAB: rd_d = {25'h0000000, y_q, 1'b0, x_q};
      A_AVGN: rd_d = {24'h000000, n_q};
      A_RATE: rd_d = {16'h0000, rate_q};
      A_DLY: rd_d = {16'h0000, dly_q};
      A_STAT: rd_d = {27'h0000000, dpend_q, sf_wait_q, run_q, stab_ok, init_q};
      A_RES: rd_d = {16'h0000, out_q};
      default: rd_d = 32'h00000000; // unmapped reads zero
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rdata <= 32'h00000000;
    else if (bus.rd) rdata <= rd_d;
    else rdata <= 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_unlock_bypass: assert property (ctrl_q.unlocked && mstep
    |=> res_v_q && out_q == $past(meas_dist)) else $error("unlocked not bypassed");
  chk_first_seed: assert property (mfirst
    |=> init_q && res_v_q && out_q == $past(meas_dist)) else $error("first not seeded");
  chk_near_pick: assert property (rej_e == REJ_NEAR && s1_v
    |-> s1_d <= meas_dist && s1_d <= ext_q) else $error("closest wrong");
  chk_far_pick: assert property (rej_e == REJ_FAR && s1_v && rcnt_q != 10'h000
    |-> s1_d >= meas_dist && s1_d >= ext_q) else $error("farthest wrong");
  chk_set_count: assert property ((rej_e == REJ_NEAR || rej_e == REJ_FAR) && mstep
    && rcnt_q != mm - 10'h001 |=> !res_v_q) else $error("set size wrong");
  chk_stab_hold: assert property (rej_e == REJ_STAB && avg_e == AVG_OFF && mstep && !stab_ok
    |=> !res_v_q && $stable(out_q)) else $error("unstable passed");
  chk_poll_refuse: assert property (ctrl_q.poll
    |-> rej_e != REJ_STAB && avg_e != AVG_RUN && lim_e != LIM_SF) else $error("poll refused");
  chk_sf_armed: assert property (sf_wait_q && ctrl_q.lim == LIM_SF && s2_v
    |=> out_q == $past(s2_d)) else $error("slow-fast early");
  chk_rate_step: assert property (lim_e == LIM_RATE && s2_v && init_q
    |=> absd(out_q, $past(out_q)) <= $past(rate_q)) else $error("rate exceeded");
  chk_box_block: assert property (avg_e == AVG_BOX && s1_v && bcnt_q != nn - 8'h01
    |=> !res_v_q) else $error("boxcar early");

  cov_set_out: cover property (rej_e == REJ_NEAR && s1_v);
  cov_run_avg: cover property (avg_e == AVG_RUN && s2_v ##1 res_v_q);
  cov_poll_queue: cover property (run_q && pend_q ##[1:50] done);
  cov_delay_out: cover property (dpend_q && tick && dcnt_q == 16'h0001);
endmodule

// ===== rtl/dfc_pkg.sv
/*
  dfc_pkg: constants, types and helpers shared by the distance filter chain.
  assumes a 100 MHz system clock and 16-bit unsigned distance words.
*/
package dfc_pkg;
  // distance word
  localparam int DW = 16;
  typedef logic [DW-1:0] dfc_dist_t;

  // register byte offsets, one 32-bit word each
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SETM = 8'h04;
  localparam logic [7:0] A_STAB = 8'h08;
  localparam logic [7:0] A_AVGN = 8'h0C;
  localparam logic [7:0] A_RATE = 8'h10;
  localparam logic [7:0] A_CODE = 8'h14;
  localparam logic [7:0] A_DLY = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1C;
  localparam logic [7:0] A_RES = 8'h20;

  // field positions in the stability register
  localparam int STAB_X_LSB = 0;
  localparam int STAB_Y_LSB = 4;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [9:0] SETM_RST = 10'h002;
  localparam logic [2:0] STABX_RST = 3'h1;
  localparam logic [2:0] STABY_RST = 3'h2;
  localparam logic [7:0] AVGN_RST = 8'h02;
  localparam logic [15:0] RATE_RST = 16'hFFFF;
  localparam logic [15:0] DLY_RST = 16'h0000;

  // configuration-mode codes
  localparam logic [7:0] CODE_SMOOTH = 8'h06;
  localparam logic [7:0] CODE_RESTORE = 8'h11;

  // timing: output delay resolution
  localparam int CLK_NS = 10;
  localparam int DLY_STEP_NS = 5000000;
  localparam int DLY_STEP_CYC = DLY_STEP_NS / CLK_NS;

  // stage selections
  typedef enum logic [1:0] {REJ_OFF, REJ_NEAR, REJ_FAR, REJ_STAB} dfc_rej_t;
  typedef enum logic [1:0] {AVG_OFF, AVG_BOX, AVG_RUN, AVG_RSV} dfc_avg_t;
  typedef enum logic [1:0] {LIM_OFF, LIM_RATE, LIM_SF, LIM_RSV} dfc_lim_t;

  // control word, low byte of the control register
  typedef struct packed {
    logic unlocked;
    logic poll;
    dfc_lim_t lim;
    dfc_avg_t avg;
    dfc_rej_t rej;
  } dfc_ctrl_t;

  // register bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } dfc_bus_t;

  // absolute difference of two distances
  function automatic dfc_dist_t absd(input dfc_dist_t a, input dfc_dist_t b);
    return (a > b) ? dfc_dist_t'(a - b) : dfc_dist_t'(b - a);
  endfunction

  // within one sixteenth of the reference word
  function automatic logic near_tol(input dfc_dist_t a, input dfc_dist_t r);
    return absd(a, r) <= (r >> 4);
  endfunction
endpackage

// ===== rtl/dfc_stab.sv
/*
  dfc_stab: history window of the last seven measurements and the
  stability vote against the latest one.
  assumes load and step are one-cycle pulses on clk, never together.
*/
`timescale 1ns/1ns
module dfc_stab (
  input wire logic clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic step,
  input wire dfc_pkg::dfc_dist_t d,
  input wire logic [2:0] x,
  input wire logic [2:0] y,
  output logic ok
);
  import dfc_pkg::*;

  dfc_dist_t hist_q [7]; // previous measurements, newest at 0
  logic [2:0] hits; // window members inside tolerance
  logic [2:0] xx; // required count, at least one

  ////////////////////////////////////////////////////////////////////
  // history shift; load seeds the whole window with the first value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 7; i++) begin
        hist_q[i] <= '0;
      end
    end else if (load) begin
      for (int i = 0; i < 7; i++) begin
        hist_q[i] <= d;
      end
    end else if (step) begin
      hist_q[0] <= d;
      for (int i = 1; i < 7; i++) begin
        hist_q[i] <= hist_q[i-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // vote: only the first y entries count
  always_comb begin
    hits = 3'h0;
    xx = (x == 3'h0) ? 3'h1 : x;
    for (int i = 0; i < 7; i++) begin
      if ((3'(i) < y) && near_tol(hist_q[i], d) && hits != 3'h7) begin
        hits = hits + 3'h1;
      end
    end
    // x above y can never pass: the target is never established
    ok = (hits >= xx);
  end
endmodule

// ===== test/dfc_src.sv
/*
  dfc_src: stand-in for the ranging engine that feeds raw distances.
  assumes the chain samples meas_valid on the rising edge of clk.
*/
`timescale 1ns/1ns
module dfc_src (
  input wire logic clk,
  output logic meas_valid,
  output dfc_pkg::dfc_dist_t meas_dist
);
  import dfc_pkg::*;
  // idle between intervals, distance word starts at zero
  initial begin
    meas_valid = 1'b0;
    meas_dist = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one measurement interval: strobe for one cycle beside the word
  task automatic send(input dfc_dist_t d);
    @(posedge clk);
    meas_valid <= 1'b1;
    meas_dist <= d;
    @(posedge clk);
    meas_valid <= 1'b0;
    // word no longer valid: show its inverse so stale reuse is caught
    meas_dist <= ~d;
  endtask
endmodule

// ===== test/test_distance_filter_chain.sv
/*
  test_distance_filter_chain: self-checking bench for the filter chain.
  assumes dfc_src drives measurements and the register port never stalls.
*/
`timescale 1ns/1ns
module test_distance_filter_chain;
  import dfc_pkg::*;
  logic clk;
  logic resetn;
  dfc_bus_t bus;
  logic [31:0] rdata;
  logic meas_valid;
  dfc_dist_t meas_dist;
  logic poll_pin;
  logic result_valid;
  dfc_dist_t result_dist;
  logic out_valid;
  dfc_dist_t out_dist;
  int err_total;
  int check_count;
  // short tick keeps the delay scenario brief
  localparam int TICK = 4;
  dfc_chain #(.DLY_TICK(TICK)) dfc_chain_inst (
    .clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
    .meas_valid(meas_valid), .meas_dist(meas_dist), .poll_pin(poll_pin),
    .result_valid(result_valid), .result_dist(result_dist),
    .out_valid(out_valid), .out_dist(out_dist)
  );
  dfc_src dfc_src_inst (.clk(clk), .meas_valid(meas_valid), .meas_dist(meas_dist));
  ////////////////////////////////////////////////////////////////////////////
  // clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // compare tasks
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: word got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk16(input dfc_dist_t g, input dfc_dist_t e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: distance got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: flag got %b want %b", $time, g, e);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // register port: one-cycle strobes, read data in the next cycle only
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    q = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    chk32(q, e);
  endtask
  // one measurement, then watch three cycles for the result strobe
  task automatic meas(input dfc_dist_t d, input logic ev, input dfc_dist_t ed);
    logic seen;
    dfc_dist_t got;
    seen = 1'b0;
    got = '0;
    dfc_src_inst.send(d);
    for (int i = 0; i < 3; i++) begin
      #1;
      if (result_valid === 1'b1) begin
        seen = 1'b1;
        got = result_dist;
      end
      @(posedge clk);
    end
    chk1(seen, ev);
    if (ev) chk16(got, ed);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_regs();
    rchk(A_CTRL, 32'h0000_0000);
    rchk(A_SETM, 32'h0000_0002);
    rchk(A_STAB, 32'h0000_0021);
    rchk(A_AVGN, 32'h0000_0002);
    rchk(A_RATE, 32'h0000_FFFF);
    rchk(A_DLY, 32'h0000_0000);
    rchk(8'h3C, 32'h0000_0000);  // unmapped reads zero
  endtask
  task automatic t_bypass();
    meas(16'h0064, 1'b1, 16'h0064);
    meas(16'h00C8, 1'b1, 16'h00C8);
    rchk(A_RES, 32'h0000_00C8);
  endtask
  task automatic t_sets();
    wr(A_SETM, 32'h3);
    wr(A_CTRL, 32'h01);
    meas(16'h0032, 1'b0, 16'h0);
    meas(16'h001E, 1'b0, 16'h0);
    meas(16'h0028, 1'b1, 16'h001E);
    wr(A_CTRL, 32'h02);
    meas(16'h0032, 1'b0, 16'h0);
    meas(16'h0050, 1'b0, 16'h0);
    meas(16'h0028, 1'b1, 16'h0050);
  endtask
  task automatic t_order();
    // closest of two, then boxcar of two: both stages in sequence
    wr(A_SETM, 32'h2);
    wr(A_AVGN, 32'h2);
    wr(A_CTRL, 32'h05);
    meas(16'h0008, 1'b0, 16'h0);
    meas(16'h0004, 1'b0, 16'h0);
    meas(16'h0006, 1'b0, 16'h0);
    meas(16'h000A, 1'b1, 16'h0005);
  endtask
  task automatic t_unlocked();
    wr(A_CTRL, 32'h85);
    meas(16'h0123, 1'b1, 16'h0123);
    meas(16'h0064, 1'b1, 16'h0064);
  endtask
  task automatic t_codes();
    wr(A_CODE, {24'h0, CODE_SMOOTH});
    rchk(A_CTRL, 32'h0000_00A5);
    rchk(A_STAT, 32'h0000_0009);
    meas(16'h0064, 1'b1, 16'h0064);
    wr(A_CODE, {24'h0, CODE_RESTORE});
    rchk(A_CTRL, 32'h0000_0000);
  endtask
  task automatic t_rate();
    wr(A_RATE, 32'h5);
    wr(A_CTRL, 32'h10);
    meas(16'h00C8, 1'b1, 16'h0069);
    meas(16'h0000, 1'b1, 16'h0064);
    wr(A_CTRL, 32'h00);
  endtask
  task automatic t_stab();
    // two of the previous three within one sixteenth
    wr(A_STAB, 32'h32);
    wr(A_CTRL, 32'h03);
    meas(16'h0100, 1'b0, 16'h0);
    meas(16'h0104, 1'b0, 16'h0);
    meas(16'h0102, 1'b1, 16'h0102);
    meas(16'h0200, 1'b0, 16'h0);
    chk16(result_dist, 16'h0102);
    meas(16'h0101, 1'b1, 16'h0101);
    wr(A_CTRL, 32'h00);
  endtask
  task automatic t_run();
    // the last stage input, 0x101, still counts in the first mean
    wr(A_CTRL, 32'h08);
    meas(16'h0105, 1'b1, 16'h0103);
    meas(16'h0111, 1'b1, 16'h010B);
    meas(16'h0121, 1'b1, 16'h0119);
  endtask
  task automatic t_sf();
    // a held jump starts one step at a time, then the step doubles
    wr(A_CTRL, 32'h20);
    meas(16'h0200, 1'b1, 16'h011A);
    meas(16'h0200, 1'b1, 16'h011B);
    meas(16'h0200, 1'b1, 16'h011D);
    meas(16'h0200, 1'b1, 16'h0121);
    wr(A_CTRL, 32'h00);
  endtask
  task automatic t_delay();
    int n;
    wr(A_DLY, 32'h2);
    dfc_src_inst.send(16'h004D);
    n = 0;
    // two ticks after the result, which comes one cycle after sampling
    while (out_valid !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk1(n >= 2 * TICK && n <= 2 * TICK + 3, 1'b1);
    chk16(out_dist, 16'h004D);
    wr(A_DLY, 32'h0);
  endtask
  task automatic t_poll();
    // stability stored but refused, measurements only inside a pass
    wr(A_CTRL, 32'h43);
    meas(16'h0011, 1'b0, 16'h0);
    // second poll lands inside the first pass and is queued
    repeat (2) begin
      @(posedge clk);
      poll_pin <= 1'b1;
      repeat (6) @(posedge clk);
      poll_pin <= 1'b0;
    end
    meas(16'h0022, 1'b1, 16'h0022);
    meas(16'h0033, 1'b1, 16'h0033);
    meas(16'h0044, 1'b0, 16'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // verdict, the only exit
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog: the run needs a few hundred cycles at most
  initial begin
    #200000;
    err_total++;
    $display("Error %0t: run timed out", $time);
    tally_and_finish();
  end
  // main sequence
  initial begin
    err_total = 0;
    check_count = 0;
    resetn = 1'b0;
    bus = '0;
    poll_pin = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_reset_regs();
    t_bypass();
    t_sets();
    t_order();
    t_unlocked();
    t_codes();
    t_rate();
    t_stab();
    t_run();
    t_sf();
    t_delay();
    t_poll();
    tally_and_finish();
  end
endmodule
